// ### shared/adc_pkg.sv
// constants, types and helpers shared by the converter control logic
`default_nettype none
package adc_pkg;
  localparam int RES_W      = 12;
  localparam int CH_W       = 5;
  localparam int NUM_INPUTS = 28;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_SC1  = 8'h00;
  localparam logic [7:0] OFS_SC2  = 8'h04;
  localparam logic [7:0] OFS_RES  = 8'h08;
  localparam logic [7:0] OFS_CMPV = 8'h0C;
  localparam logic [7:0] OFS_CFG  = 8'h10;

  // field positions
  localparam int SC1_DONE    = 7;
  localparam int SC1_IEN     = 6;
  localparam int SC1_CONT    = 5;
  localparam int SC2_ACT     = 7;
  localparam int SC2_HWT     = 6;
  localparam int SC2_CFE     = 5;
  localparam int SC2_GE      = 4;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_FMT_LSB = 2;
  localparam int CFG_SRC_LSB = 0;

  // channel codes
  localparam logic [CH_W-1:0] CH_RSV24 = 5'h18;
  localparam logic [CH_W-1:0] CH_RSV25 = 5'h19;
  localparam logic [CH_W-1:0] CH_TEMP  = 5'h1A;
  localparam logic [CH_W-1:0] CH_BGAP  = 5'h1B;
  localparam logic [CH_W-1:0] CH_RSV28 = 5'h1C;
  localparam logic [CH_W-1:0] CH_OFF   = 5'h1F;

  // reset values
  localparam logic [CH_W-1:0] CHAN_RESET = CH_OFF;

  // timing
  localparam logic [3:0] SAMPLE_TICKS    = 4'h4;
  // cycles the comparator answer needs to cross its synchroniser after a new trial code
  localparam logic [2:0] CMP_SETTLE      = 3'h5;
  localparam int         CLK_PERIOD_NS   = 5;
  localparam int         LOCAL_PERIOD_NS = 200;
  localparam logic [5:0] LOCAL_CYCLES    = 6'(LOCAL_PERIOD_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    SRC_BUS      = 2'b00,
    SRC_BUS_HALF = 2'b01,
    SRC_ALT      = 2'b10,
    SRC_LOCAL    = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    FMT_8  = 2'b00,
    FMT_12 = 2'b01,
    FMT_10 = 2'b10
  } fmt_t;

  typedef enum logic [1:0] {
    SAR_IDLE    = 2'b00,
    SAR_SAMPLE  = 2'b01,
    SAR_CONVERT = 2'b10
  } sar_state_t;

  // three-stage synchroniser: a change counts once stages two and three agree
  function automatic logic sync_filter(logic [2:0] sy, logic prev);
    return (sy[1] == sy[2]) ? sy[2] : prev;
  endfunction : sync_filter
endpackage : adc_pkg
`default_nettype wire

// ### shared/conv_if.sv
// handshake between the control front end and the approximation engine
`timescale 1ns/100ps
`default_nettype none
interface conv_if;
  import adc_pkg::*;
  logic             tick;
  logic             start;
  logic             abort;
  logic             cmp;
  logic             busy;
  logic             done;
  logic [RES_W-1:0] code;
  modport ctrl (output tick, output start, output abort, output cmp,
                input busy, input done, input code);
  modport eng  (input tick, input start, input abort, input cmp,
                output busy, output done, output code);
endinterface : conv_if
`default_nettype wire

// ### logic/sar_engine.sv
// successive approximation sequencer: sample phase, then one bit per tick
`timescale 1ns/100ps
`default_nettype none
module sar_engine (
  input  wire logic clock,
  input  wire logic rst_b,
  conv_if.eng       cv
);
  import adc_pkg::*;

  typedef struct packed {
    sar_state_t       state;
    logic [RES_W-1:0] code;
    logic [3:0]       bit_idx;
    logic [3:0]       cnt;
    logic             done;
  } eng_t;

  eng_t s_reg;
  eng_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (cv.start) begin
      s_next.state = SAR_SAMPLE;
      s_next.cnt   = 4'h0;
      s_next.code  = '0;
    end else if (cv.abort) begin
      s_next.state = SAR_IDLE;
    end else begin
      unique case (s_reg.state)
        SAR_IDLE: begin
        end
        SAR_SAMPLE: begin
          if (cv.tick) begin
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == SAMPLE_TICKS - 4'h1) begin
              s_next.state   = SAR_CONVERT;
              s_next.bit_idx = 4'(RES_W - 1);
              s_next.code    = 12'h800;
            end
          end
        end
        SAR_CONVERT: begin
          // comparator high means the input is at or above the trial level
          if (cv.tick) begin
            if (!cv.cmp) s_next.code[s_reg.bit_idx] = 1'b0;
            if (s_reg.bit_idx == 4'h0) begin
              s_next.done  = 1'b1;
              s_next.state = SAR_IDLE;
            end else begin
              s_next.bit_idx                   = s_reg.bit_idx - 4'h1;
              s_next.code[s_reg.bit_idx - 4'h1] = 1'b1;
            end
          end
        end
        default: s_next.state = SAR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cv.code = s_reg.code;
  assign cv.done = s_reg.done;
  assign cv.busy = (s_reg.state != SAR_IDLE);
endmodule : sar_engine
`default_nettype wire

// ### logic/sar_adc_front_control.sv
// control front end of the 12-bit converter: APB registers, clocking, triggers
`timescale 1ns/100ps
`default_nettype none
module sar_adc_front_control (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 alternate_clock_input,
  input  wire logic                 hardware_trigger_input,
  input  wire logic                 comparator_in,
  input  wire logic                 wait_mode,
  input  wire logic                 stop2_mode,
  input  wire logic                 stop3_mode,
  output logic [adc_pkg::CH_W-1:0]  channel_select,
  output logic                      temp_sensor_en,
  output logic                      bandgap_en,
  output logic                      converter_power,
  output logic [adc_pkg::RES_W-1:0] dac_code,
  output logic                      conv_irq
);
  import adc_pkg::*;

  typedef struct packed {
    logic [2:0]       trig_sync;
    logic [2:0]       alt_sync;
    logic [2:0]       cmp_sync;
    logic             trig_f;
    logic             alt_f;
    logic             cmp_f;
    logic [CH_W-1:0]  chan;
    logic             ien;
    logic             cont;
    logic             hwt;
    logic             cfe;
    logic             ge;
    logic             done;
    logic [1:0]       src;
    logic [1:0]       fmt;
    logic [1:0]       div;
    logic [RES_W-1:0] cmpv;
    logic [RES_W-1:0] result;
    logic             half_tgl;
    logic [5:0]       local_cnt;
    logic [2:0]       div_cnt;
    logic             tick;
    logic             pend;
    logic [2:0]       settle;
    logic             start;
    logic             abort;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             irq;
    logic [CH_W-1:0]  mux_sel;
    logic             temp_en;
    logic             bg_en;
    logic             powered;
  } st_t;

  st_t    s_reg;
  st_t    s_next;
  conv_if cv ();

  sar_engine u_engine (
    .clock (clock),
    .rst_b (rst_b),
    .cv    (cv.eng)
  );

  logic             setup;
  logic             access;
  logic             mapped;
  logic             src_en;
  logic             trig_rise;
  logic             alt_rise;
  logic             cmp_ok;
  logic             wr_sc1;
  logic             rd_res;
  logic             busy_any;
  logic             clk_gone;
  logic [2:0]       div_last;
  logic [RES_W-1:0] fres;

  assign setup  = psel & ~penable;
  assign access = psel & penable & s_reg.pready;

  always_comb begin
    unique case (paddr)
      OFS_SC1, OFS_SC2, OFS_RES, OFS_CMPV, OFS_CFG: mapped = 1'b1;
      default:                                      mapped = 1'b0;
    endcase
  end

  always_comb begin
    s_next    = s_reg;
    src_en    = 1'b0;
    fres      = '0;
    cmp_ok    = 1'b0;
    div_last  = 3'((4'h1 << s_reg.div) - 4'h1);
    busy_any  = cv.busy | s_reg.start;
    wr_sc1    = access & pwrite & ~s_reg.pslverr & (paddr == OFS_SC1);
    rd_res    = access & ~pwrite & ~s_reg.pslverr & (paddr == OFS_RES);

    // pins from other domains: three stages, second and third must agree
    s_next.trig_sync = {s_reg.trig_sync[1:0], hardware_trigger_input};
    s_next.alt_sync  = {s_reg.alt_sync[1:0], alternate_clock_input};
    s_next.cmp_sync  = {s_reg.cmp_sync[1:0], comparator_in};
    s_next.trig_f    = sync_filter(s_reg.trig_sync, s_reg.trig_f);
    s_next.alt_f     = sync_filter(s_reg.alt_sync, s_reg.alt_f);
    s_next.cmp_f     = sync_filter(s_reg.cmp_sync, s_reg.cmp_f);
    trig_rise        = s_next.trig_f & ~s_reg.trig_f;
    alt_rise         = s_next.alt_f & ~s_reg.alt_f;

    // source clock enables; the local oscillator is a free divider of the bus clock
    s_next.half_tgl  = ~s_reg.half_tgl;
    s_next.local_cnt = (s_reg.local_cnt == LOCAL_CYCLES - 6'h1) ? 6'h0
                                                                : s_reg.local_cnt + 6'h1;
    unique case (clk_src_t'(s_reg.src))
      SRC_BUS:      src_en = 1'b1;
      SRC_BUS_HALF: src_en = s_reg.half_tgl;
      SRC_ALT:      src_en = alt_rise;
      SRC_LOCAL:    src_en = (s_reg.local_cnt == 6'h0);
    endcase
    // bus and alternate clocks are gone in stop3; only the local one survives
    clk_gone = stop2_mode || (stop3_mode && s_reg.src != SRC_LOCAL);
    if (clk_gone) src_en = 1'b0;

    s_next.tick   = 1'b0;
    s_next.settle = (s_reg.settle != 3'h0) ? s_reg.settle - 3'h1 : 3'h0;
    if (src_en) begin
      if (s_reg.div_cnt >= div_last) begin
        s_next.div_cnt = 3'h0;
        s_next.pend    = 1'b1;
      end else begin
        s_next.div_cnt = s_reg.div_cnt + 3'h1;
      end
    end
    // the comparator answer crosses three synchroniser flops and the filter flop, so each trial code needs time to
    // reach the engine; fast settings therefore convert slower than the divider asks
    if (s_next.pend && s_reg.settle == 3'h0 && !clk_gone) begin
      s_next.pend   = 1'b0;
      s_next.tick   = 1'b1;
      s_next.settle = CMP_SETTLE;
    end

    // conversion results: format, compare, latch
    unique case (s_reg.fmt)
      FMT_10:  fres = {2'h0, cv.code[RES_W-1:2]};
      FMT_8:   fres = {4'h0, cv.code[RES_W-1:4]};
      default: fres = cv.code;
    endcase
    cmp_ok = s_reg.ge ? (fres >= s_reg.cmpv) : (fres < s_reg.cmpv);

    // flag clear by control write or result read; a same-cycle set wins below
    if (wr_sc1 || rd_res) s_next.done = 1'b0;
    if (cv.done && (!s_reg.cfe || cmp_ok)) begin
      s_next.done   = 1'b1;
      s_next.result = fres;
    end

    // conversion starts
    s_next.start = 1'b0;
    s_next.abort = 1'b0;
    if (cv.done && s_reg.cont && s_reg.chan != CH_OFF && !stop2_mode) begin
      s_next.start = 1'b1;
    end
    if (trig_rise && s_reg.hwt && !busy_any && s_reg.chan != CH_OFF && !stop2_mode) begin
      s_next.start = 1'b1;
    end

    // APB register access
    s_next.pready  = setup;
    s_next.pslverr = setup & ~mapped;
    s_next.prdata  = 32'h0;
    if (setup && !pwrite) begin
      unique case (paddr)
        OFS_SC1:  s_next.prdata = {24'h0, s_reg.done, s_reg.ien, s_reg.cont, s_reg.chan};
        OFS_SC2:  s_next.prdata = {24'h0, busy_any, s_reg.hwt, s_reg.cfe, s_reg.ge, 4'h0};
        OFS_RES:  s_next.prdata = {20'h0, s_reg.result};
        OFS_CMPV: s_next.prdata = {20'h0, s_reg.cmpv};
        OFS_CFG:  s_next.prdata = {25'h0, s_reg.div, 1'b0, s_reg.fmt, s_reg.src};
        default:  s_next.prdata = 32'h0;
      endcase
    end
    if (access && pwrite && !s_reg.pslverr) begin
      unique case (paddr)
        OFS_SC1: begin
          s_next.ien   = pwdata[SC1_IEN];
          s_next.cont  = pwdata[SC1_CONT];
          s_next.chan  = pwdata[CH_W-1:0];
          s_next.abort = 1'b1;
          // all ones only stops; reserved codes still run a conversion
          s_next.start = (pwdata[CH_W-1:0] != CH_OFF) && !s_reg.hwt
                         && !stop2_mode;
        end
        OFS_SC2: begin
          s_next.hwt = pwdata[SC2_HWT];
          s_next.cfe = pwdata[SC2_CFE];
          s_next.ge  = pwdata[SC2_GE];
        end
        OFS_CMPV: s_next.cmpv = pwdata[RES_W-1:0];
        OFS_CFG: begin
          s_next.div = pwdata[CFG_DIV_LSB +: 2];
          s_next.fmt = pwdata[CFG_FMT_LSB +: 2];
          s_next.src = pwdata[CFG_SRC_LSB +: 2];
        end
        default: s_next.cmpv = s_reg.cmpv;
      endcase
    end
    if (stop2_mode) s_next.abort = 1'b1;

    // analog side routing
    s_next.powered = (s_next.chan != CH_OFF) && !stop2_mode;
    s_next.mux_sel = s_next.chan;
    s_next.temp_en = s_next.powered && (s_next.chan == CH_TEMP);
    s_next.bg_en   = s_next.powered && (s_next.chan == CH_BGAP);
    s_next.irq     = s_next.done & s_next.ien;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_reg      <= '0;
      s_reg.chan <= CHAN_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cv.tick  = s_reg.tick;
  assign cv.start = s_reg.start;
  assign cv.abort = s_reg.abort;
  assign cv.cmp   = s_reg.cmp_f;

  assign prdata          = s_reg.prdata;
  assign pready          = s_reg.pready;
  assign pslverr         = s_reg.pslverr;
  assign channel_select  = s_reg.mux_sel;
  assign temp_sensor_en  = s_reg.temp_en;
  assign bandgap_en      = s_reg.bg_en;
  assign converter_power = s_reg.powered;
  assign dac_code        = cv.code;
  assign conv_irq        = s_reg.irq;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  apb_ready_a: assert property (setup |=> pready ##1 !pready)
    else $error("bus access phase did not see pready exactly once");

  unmapped_err_a: assert property ((setup && !mapped) |=> pslverr && pready)
    else $error("unmapped access not flagged");

  off_no_start_a: assert property (s_reg.start |-> s_reg.chan != CH_OFF)
    else $error("conversion started with channel field all ones");

  sc1_abort_a: assert property (wr_sc1 |=> s_reg.abort)
    else $error("control write did not abort the running conversion");

  sc1_restart_a: assert property ((wr_sc1 && pwdata[CH_W-1:0] != CH_OFF && !s_reg.hwt
                                   && !stop2_mode) |=> s_reg.start ##1 cv.busy)
    else $error("control write did not restart a conversion");

  done_set_a: assert property ((cv.done && !s_reg.cfe) |=> s_reg.done)
    else $error("completion flag not set after conversion");

  done_cmp_a: assert property ((cv.done && s_reg.cfe && !cmp_ok && !s_reg.done)
                               |=> !s_reg.done)
    else $error("completion flag set although compare was false");

  done_clear_a: assert property ((rd_res && !cv.done) |=> !s_reg.done)
    else $error("result read did not clear completion flag");

  irq_follow_a: assert property ((s_reg.done && s_reg.ien) |-> conv_irq)
    else $error("interrupt request missing while flag and enable are set");

  alt_stop_a: assert property ((stop2_mode || (stop3_mode && s_reg.src != SRC_LOCAL))
                               |=> !s_reg.tick)
    else $error("conversion clock ran from a source stopped in low power");

  narrow_fmt_a: assert property ((cv.done && !s_reg.cfe && s_reg.fmt == FMT_8)
                                 |=> s_reg.result[RES_W-1:8] == 4'h0)
    else $error("upper result bits not zero in 8-bit format");

  temp_route_a: assert property ((s_next.chan == CH_TEMP && !stop2_mode) |=> temp_sensor_en
                                 && !bandgap_en)
    else $error("temperature sensor not routed");

  single_idle_a: assert property ((cv.done && !s_reg.cont && !s_reg.hwt && !wr_sc1
                                   && !s_reg.start)
                                  |=> !s_reg.start ##1 !cv.busy)
    else $error("single conversion did not return to idle");

  // a trial decided on a stale comparator answer gives a wrong bit, not an error
  tick_gap_a: assert property (s_reg.tick |=> (!s_reg.tick) [*5])
    else $error("trial tick came before the comparator had settled");

  wait_alt_a: assert property ((wait_mode && !stop2_mode && !stop3_mode
                                && s_reg.src == SRC_ALT) |-> src_en == alt_rise)
    else $error("alternate clock gated while the core waits");

  // stop2 powers the converter down, so a running conversion is dropped
  stop2_off_a: assert property (stop2_mode |=> s_reg.abort && !converter_power)
    else $error("stop2 left the converter running");

  conv_done_c: cover property (cv.done ##1 s_reg.done);
  cont_run_c:  cover property (cv.done && s_reg.cont ##2 cv.busy);
  hw_start_c:  cover property (s_reg.hwt && trig_rise ##1 s_reg.start);
  cmp_hit_c:   cover property (cv.done && s_reg.cfe && cmp_ok);
  stop3_run_c: cover property (stop3_mode && s_reg.src == SRC_LOCAL && cv.done);
endmodule : sar_adc_front_control
`default_nettype wire

// ### bench/analog_model.sv
// far side model: analog inputs seen through the comparator, counter trigger, alternate clock
`timescale 1ns/100ps
`default_nettype none
module analog_model #(
  parameter int RTC_PERIOD = 64,
  parameter int ALT_HALF   = 8
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [4:0]  channel_select,
  input  wire logic        converter_power,
  input  wire logic [11:0] dac_code,
  input  wire logic        rtc_en,
  output logic             comparator_in,
  output logic             hardware_trigger_input,
  output logic             alternate_clock_input
);
  int rtc_cnt;
  int alt_cnt;
  // each channel carries its own fixed level so a wrong mux setting shows in the result
  assign comparator_in = converter_power && ({channel_select, 7'h25} >= dac_code);
  // external reference clock runs free, unrelated to the trial timing
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      alt_cnt <= 0;
      alternate_clock_input <= 1'b0;
    end else if (alt_cnt == ALT_HALF - 1) begin
      alt_cnt <= 0;
      alternate_clock_input <= !alternate_clock_input;
    end else begin
      alt_cnt <= alt_cnt + 1;
    end
  end
  // counter overflow held high a few cycles so the synchroniser cannot miss it
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rtc_cnt <= 0;
      hardware_trigger_input <= 1'b0;
    end else begin
      rtc_cnt <= rtc_en ? ((rtc_cnt == RTC_PERIOD - 1) ? 0 : rtc_cnt + 1) : 0;
      hardware_trigger_input <= rtc_en && (rtc_cnt >= RTC_PERIOD - 4);
    end
  end
endmodule : analog_model
`default_nettype wire

// ### bench/sar_adc_front_control_test.sv
// self-checking bench for the converter control front end
`timescale 1ns/100ps
`default_nettype none
module sar_adc_front_control_test;
  import adc_pkg::*;
  logic        clock, rst_b, psel, penable, pwrite, wait_mode, stop2_mode, stop3_mode, rtc_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, e, temp_sensor_en, bandgap_en, converter_power, conv_irq;
  logic [4:0]  channel_select;
  logic [11:0] dac_code;
  wire logic   comparator_in, hardware_trigger_input, alternate_clock_input;
  int          n_mismatch, tests_run;

  sar_adc_front_control dut (.clock(clock), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alternate_clock_input(alternate_clock_input),
    .hardware_trigger_input(hardware_trigger_input), .comparator_in(comparator_in),
    .wait_mode(wait_mode), .stop2_mode(stop2_mode), .stop3_mode(stop3_mode),
    .channel_select(channel_select), .temp_sensor_en(temp_sensor_en), .bandgap_en(bandgap_en),
    .converter_power(converter_power), .dac_code(dac_code), .conv_irq(conv_irq));
  analog_model model (.clock(clock), .rst_b(rst_b), .channel_select(channel_select),
    .converter_power(converter_power), .dac_code(dac_code), .rtc_en(rtc_en),
    .comparator_in(comparator_in), .hardware_trigger_input(hardware_trigger_input),
    .alternate_clock_input(alternate_clock_input));

  function automatic logic [31:0] lvl(input logic [4:0] ch);
    return {20'h00000, ch, 7'h25};
  endfunction : lvl

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one transfer, then an idle edge so the next setup never lands in the same step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50) n_mismatch++;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(q, exp);
  endtask : rd

  task automatic wait_done(input logic expect_done);
    int n;
    n = 0;
    do begin
      apb(OFS_SC1, 1'b0, 32'h0);
      n++;
    end while (q[SC1_DONE] !== 1'b1 && n < 300);
    chk({31'h0, q[SC1_DONE]}, {31'h0, expect_done});
  endtask : wait_done

  task automatic conv(input logic [31:0] cfg, input logic [4:0] ch, input logic [31:0] exp);
    wr(OFS_CFG, cfg);
    wr(OFS_SC1, {27'h0, ch});
    wait_done(1'b1);
    rd(OFS_RES, exp);
    rd(OFS_SC1, {27'h0, ch});
  endtask : conv

  task automatic t_reset();
    rd(OFS_SC1, 32'h1F);
    rd(OFS_SC2, 32'h0);
    rd(OFS_CFG, 32'h0);
    rd(OFS_CMPV, 32'h0);
    apb(8'h14, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    chk({27'h0, channel_select}, 32'h1F);
    chk({31'h0, converter_power}, 32'h0);
  endtask : t_reset

  task automatic t_sources();
    // bus clock slowed by the divider; alternate converted while the core waits
    conv(32'h64, 5'd1, lvl(5'd1));
    conv(32'h45, 5'd2, lvl(5'd2));
    wait_mode <= 1'b1;
    conv(32'h06, 5'd3, lvl(5'd3));
    wait_mode <= 1'b0;
    conv(32'h07, 5'd23, lvl(5'd23));
    chk({31'h0, converter_power}, 32'h1);
    chk({27'h0, channel_select}, 32'd23);
  endtask : t_sources

  task automatic t_formats();
    conv(32'h60, 5'd3, lvl(5'd3) >> 4);
    conv(32'h68, 5'd3, lvl(5'd3) >> 2);
  endtask : t_formats

  task automatic t_special();
    // bandgap before temperature, as software is expected to sequence them
    conv(32'h64, CH_BGAP, lvl(CH_BGAP));
    chk({30'h0, bandgap_en, temp_sensor_en}, 32'h2);
    conv(32'h64, CH_TEMP, lvl(CH_TEMP));
    chk({30'h0, bandgap_en, temp_sensor_en}, 32'h1);
    wr(OFS_SC1, {27'h0, CH_RSV28});
    wait_done(1'b1);
    wr(OFS_SC1, {27'h0, CH_RSV24});
    wait_done(1'b1);
  endtask : t_special

  task automatic t_irq();
    wr(OFS_SC1, 32'h45);
    wait_done(1'b1);
    chk({31'h0, conv_irq}, 32'h1);
    chk({20'h0, dac_code}, lvl(5'd5));
    rd(OFS_RES, lvl(5'd5));
    repeat (2) @(posedge clock);
    chk({31'h0, conv_irq}, 32'h0);
  endtask : t_irq

  task automatic t_compare();
    wr(OFS_CMPV, 32'h300);
    wr(OFS_SC2, 32'h30);
    wr(OFS_SC1, 32'h05);
    wait_done(1'b0);
    wr(OFS_SC2, 32'h20);
    conv(32'h64, 5'd5, lvl(5'd5));
    wr(OFS_SC2, 32'h0);
  endtask : t_compare

  task automatic t_cont();
    wr(OFS_SC1, 32'h24);
    wait_done(1'b1);
    rd(OFS_RES, lvl(5'd4));
    wait_done(1'b1);
    rd(OFS_RES, lvl(5'd4));
    wr(OFS_SC1, 32'h1F);
    repeat (300) @(posedge clock);
    rd(OFS_SC1, 32'h1F);
    rd(OFS_SC2, 32'h0);
    chk({31'h0, converter_power}, 32'h0);
  endtask : t_cont

  task automatic t_hwtrig();
    wr(OFS_SC2, 32'h40);
    wr(OFS_SC1, 32'h07);
    repeat (300) @(posedge clock);
    rd(OFS_SC1, 32'h07);
    rtc_en <= 1'b1;
    wait_done(1'b1);
    rtc_en <= 1'b0;
    rd(OFS_RES, lvl(5'd7));
    wr(OFS_SC2, 32'h0);
  endtask : t_hwtrig

  task automatic t_abort();
    wr(OFS_SC1, 32'h02);
    repeat (20) @(posedge clock);
    wr(OFS_SC1, 32'h09);
    wait_done(1'b1);
    rd(OFS_RES, lvl(5'd9));
  endtask : t_abort

  task automatic t_stop();
    stop3_mode <= 1'b1;
    wr(OFS_CFG, 32'h06);
    wr(OFS_SC1, 32'h06);
    wait_done(1'b0);
    conv(32'h07, 5'd6, lvl(5'd6));
    stop3_mode <= 1'b0;
    stop2_mode <= 1'b1;
    repeat (4) @(posedge clock);
    chk({31'h0, converter_power}, 32'h0);
    stop2_mode <= 1'b0;
  endtask : t_stop

  initial begin
    clock = 1'b0;
    forever #2.5 clock = !clock;
  end

  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end

  initial begin
    n_mismatch = 0; tests_run = 0; rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; wait_mode = 1'b0; stop2_mode = 1'b0; stop3_mode = 1'b0;
    rtc_en = 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset();
    t_sources();
    t_formats();
    t_special();
    t_irq();
    t_compare();
    t_cont();
    t_hwtrig();
    t_abort();
    t_stop();
    end_sim();
  end
endmodule : sar_adc_front_control_test
`default_nettype wire
